//--- shared/fstc_defs.svh
// Purpose: offsets, field positions, reset values and timing counts of the frame start trigger control
// Assumes: 32-bit register words at aligned byte offsets, 100 MHz system clock
// Notes: definitions only
`ifndef FSTC_DEFS_SVH
`define FSTC_DEFS_SVH

// register offsets
`define FSTC_OFF_CTRL 8'h00
`define FSTC_OFF_CMD 8'h04
`define FSTC_OFF_RATE 8'h08
`define FSTC_OFF_MINP 8'h0c
`define FSTC_OFF_SHUT 8'h10
`define FSTC_OFF_STAT 8'h14
`define FSTC_OFF_APPL 8'h18

// control field positions
`define FSTC_CTRL_ONE_SHOT 0
`define FSTC_CTRL_EXT_EN 1
`define FSTC_CTRL_ORIGIN 2
`define FSTC_CTRL_POLARITY 3
`define FSTC_CTRL_STYLE 4
`define FSTC_CTRL_FAST 5

// command field positions
`define FSTC_CMD_ARM 0
`define FSTC_CMD_DISARM 1
`define FSTC_CMD_FIRE 2

// reset values
`define FSTC_RST_CTRL 6'h00
`define FSTC_RST_RATE 32'h000f4240
`define FSTC_RST_MINP 32'h00001000
`define FSTC_RST_SHUT 32'h00000100

// timing
`define FSTC_CLK_PERIOD_NS 10
`define FSTC_START_DELAY_NS 50
`define FSTC_READOUT_NS 160
`define FSTC_START_DELAY_CYC ((`FSTC_START_DELAY_NS + `FSTC_CLK_PERIOD_NS - 1) / `FSTC_CLK_PERIOD_NS)
`define FSTC_READOUT_CYC ((`FSTC_READOUT_NS + `FSTC_CLK_PERIOD_NS - 1) / `FSTC_CLK_PERIOD_NS)

`endif

//--- shared/fstc_pkg.sv
// Purpose: types of the frame start trigger control
// Assumes: nothing
// Notes: state codes step in gray order along the frame path
package fstc_pkg;

    typedef enum logic [2:0] {
        FSTC_ST_IDLE = 3'h0,
        FSTC_ST_WAIT = 3'h1,
        FSTC_ST_DLY = 3'h3,
        FSTC_ST_EXP = 3'h2,
        FSTC_ST_RD = 3'h6
    } fstc_state_type;

endpackage : fstc_pkg

//--- rtl/fstc_cycle_timer.sv
// Purpose: loadable down counter for phase and pacing lengths
// Assumes: load value is length minus one
// Notes: expired while count is zero
`timescale 1ns/1ps
`default_nettype none

module fstc_cycle_timer (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic load,
    input wire logic [31:0] load_val,
    // status
    output logic expired,
    output logic [31:0] count
);

    logic [31:0] count_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            count_q <= 32'h0;
        end else if (load) begin
            count_q <= load_val;
        end else if (count_q != 32'h0) begin
            count_q <= count_q - 32'h1;
        end
    end

    assign expired = (count_q == 32'h0);
    assign count = count_q;

    chk_count_steps_down: assert property (@(posedge clk) disable iff (rst)
        (!load && count_q != 32'h0) |=> count_q == $past(count_q) - 32'h1)
        else $error("timer did not step down");

endmodule : fstc_cycle_timer

`default_nettype wire

//--- rtl/fstc_edge_sync.sv
// Purpose: two-stage synchroniser and polarity-aware edge finder for the trigger line
// Assumes: polarity 0 rising, 1 falling
// Notes: first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none

module fstc_edge_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // line and polarity
    input wire logic line_in,
    input wire logic polarity,
    // results
    output logic level_active,
    output logic start_edge,
    output logic end_edge
);

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic act2;
    logic act3;

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= line_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign act2 = s2_q ^ polarity;
    assign act3 = s3_q ^ polarity;
    assign level_active = act2;
    assign start_edge = act2 && !act3;
    assign end_edge = !act2 && act3;

    chk_rise_after_sync: assert property (@(posedge clk) disable iff (rst)
        (start_edge && !polarity && $stable(polarity)) |-> ($past(line_in, 2) && !$past(line_in, 3)))
        else $error("rising edge not two stages behind the line");

endmodule : fstc_edge_sync

`default_nettype wire

//--- rtl/fstc_frame_trigger.sv
// Purpose: frame start trigger control with free run, software and hardware triggering
// Assumes: registers over a plain strobe port, read data one cycle after the read strobe
// Notes:
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fstc_defs.svh"

module fstc_frame_trigger
    import fstc_pkg::*;
(
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    // trigger line
    input wire logic HW_TRIGGER_INPUT,
    // acquisition status
    output logic EXPOSURE_ACTIVE,
    output logic FRAME_START,
    output logic FRAME_BUSY,
    output logic ACQ_ARMED
);

    function automatic logic [31:0] fstc_m1(input logic [31:0] v);
        return (v == 32'h0) ? 32'h0 : v - 32'h1;
    endfunction : fstc_m1

    ////////////////////////////////////////////////////////////////////////////
    // registers and decode

    logic [5:0] ctrl_q;
    logic [31:0] rate_q;
    logic [31:0] minp_q;
    logic [31:0] shutter_q;
    logic [31:0] eff_shutter_q;
    logic [15:0] frame_cnt_q;
    logic armed_q;
    logic armed_d;
    logic shot_pend_q;
    logic shot_pend_d;
    logic pend_q;
    logic pend_d;
    fstc_state_type state_q;
    fstc_state_type state_d;
    logic [31:0] rdata_d;

    wire wr_ctrl = REG_WR && (REG_ADDR == `FSTC_OFF_CTRL);
    wire wr_cmd = REG_WR && (REG_ADDR == `FSTC_OFF_CMD);
    wire wr_rate = REG_WR && (REG_ADDR == `FSTC_OFF_RATE);
    wire wr_minp = REG_WR && (REG_ADDR == `FSTC_OFF_MINP);
    wire wr_shut = REG_WR && (REG_ADDR == `FSTC_OFF_SHUT);

    wire arm_cmd = wr_cmd && REG_WDATA[`FSTC_CMD_ARM];
    wire disarm_cmd = wr_cmd && REG_WDATA[`FSTC_CMD_DISARM];
    wire soft_fire_cmd = wr_cmd && REG_WDATA[`FSTC_CMD_FIRE];

    wire capture_run_style = ctrl_q[`FSTC_CTRL_ONE_SHOT];
    wire external_trigger_enable = ctrl_q[`FSTC_CTRL_EXT_EN];
    wire trigger_origin_sel = ctrl_q[`FSTC_CTRL_ORIGIN];
    wire edge_polarity_sel = ctrl_q[`FSTC_CTRL_POLARITY];
    wire shutter_style = ctrl_q[`FSTC_CTRL_STYLE];
    wire fast_exposure_start = ctrl_q[`FSTC_CTRL_FAST];
    wire one_shot = capture_run_style;

    ////////////////////////////////////////////////////////////////////////////
    // hardware line and timers

    logic level_active;
    logic start_edge;
    logic end_edge;
    logic ph_expired;
    logic [31:0] ph_count;
    logic ph_load;
    logic [31:0] ph_val;
    logic pace_expired;
    logic [31:0] pace_count;

    fstc_edge_sync u_edge (
        .clk(CLK_SYS),
        .rst(RST),
        .line_in(HW_TRIGGER_INPUT),
        .polarity(edge_polarity_sel),
        .level_active(level_active),
        .start_edge(start_edge),
        .end_edge(end_edge)
    );

    fstc_cycle_timer u_phase (
        .clk(CLK_SYS),
        .rst(RST),
        .load(ph_load),
        .load_val(ph_val),
        .expired(ph_expired),
        .count(ph_count)
    );

    ////////////////////////////////////////////////////////////////////////////
    // trigger selection

    wire fast_eff = fast_exposure_start && external_trigger_enable;
    wire hw_src = external_trigger_enable && trigger_origin_sel;
    wire width_mode = hw_src && shutter_style;
    wire in_wait = (state_q == FSTC_ST_WAIT);
    wire run_cont = !external_trigger_enable && !one_shot && armed_q;
    wire [31:0] pace_period = (rate_q < minp_q) ? minp_q : rate_q;
    wire pace_load = arm_cmd || (run_cont && pace_expired);
    wire [31:0] pace_val = arm_cmd ? 32'h1 : fstc_m1(pace_period);
    wire ext_trig = trigger_origin_sel ? start_edge : soft_fire_cmd;
    wire late_width = width_mode && pend_q && level_active;
    wire int_trig = one_shot ? shot_pend_q : (run_cont && pace_expired);
    wire trig = external_trigger_enable ? (ext_trig || late_width) : int_trig;
    wire accept = in_wait && armed_q && trig;
    wire frame_end = (state_q == FSTC_ST_RD) && ph_expired;
    wire [31:0] dly_m1 = 32'(`FSTC_START_DELAY_CYC) - 32'h1;
    wire [31:0] rd_m1 = 32'(`FSTC_READOUT_CYC) - 32'h1;

    fstc_cycle_timer u_pace (
        .clk(CLK_SYS),
        .rst(RST),
        .load(pace_load),
        .load_val(pace_val),
        .expired(pace_expired),
        .count(pace_count)
    );

    ////////////////////////////////////////////////////////////////////////////
    // frame sequence

    always_comb begin
        state_d = state_q;
        ph_load = 1'b0;
        ph_val = 32'h0;
        case (state_q)
            FSTC_ST_IDLE: begin
                if (armed_q) begin
                    state_d = FSTC_ST_WAIT;
                end
            end
            FSTC_ST_WAIT: begin
                if (!armed_q) begin
                    state_d = FSTC_ST_IDLE;
                end else if (accept && fast_eff) begin
                    state_d = FSTC_ST_EXP;
                    ph_load = 1'b1;
                    ph_val = fstc_m1(eff_shutter_q);
                end else if (accept) begin
                    state_d = FSTC_ST_DLY;
                    ph_load = 1'b1;
                    ph_val = dly_m1;
                end
            end
            FSTC_ST_DLY: begin
                if (ph_expired) begin
                    state_d = FSTC_ST_EXP;
                    ph_load = 1'b1;
                    ph_val = fstc_m1(eff_shutter_q);
                end
            end
            FSTC_ST_EXP: begin
                if (width_mode ? !level_active : ph_expired) begin
                    state_d = FSTC_ST_RD;
                    ph_load = 1'b1;
                    ph_val = rd_m1;
                end
            end
            FSTC_ST_RD: begin
                if (ph_expired) begin
                    state_d = (armed_q && !one_shot) ? FSTC_ST_WAIT : FSTC_ST_IDLE;
                end
            end
            default: begin
                state_d = FSTC_ST_IDLE;
            end
        endcase
    end

    assign armed_d = arm_cmd ? 1'b1 : ((disarm_cmd || (frame_end && one_shot)) ? 1'b0 : armed_q);
    assign shot_pend_d = (arm_cmd && !external_trigger_enable && one_shot) ? 1'b1 :
                         ((accept || disarm_cmd) ? 1'b0 : shot_pend_q);
    assign pend_d = (start_edge && !in_wait && width_mode) ? 1'b1 :
                    ((!level_active || accept) ? 1'b0 : pend_q);

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state_q <= FSTC_ST_IDLE;
            armed_q <= 1'b0;
            shot_pend_q <= 1'b0;
            pend_q <= 1'b0;
            frame_cnt_q <= 16'h0;
        end else begin
            state_q <= state_d;
            armed_q <= armed_d;
            shot_pend_q <= shot_pend_d;
            pend_q <= pend_d;
            frame_cnt_q <= accept ? frame_cnt_q + 16'h1 : frame_cnt_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // settings and applied shutter

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ctrl_q <= `FSTC_RST_CTRL;
            rate_q <= `FSTC_RST_RATE;
            minp_q <= `FSTC_RST_MINP;
            shutter_q <= `FSTC_RST_SHUT;
        end else begin
            ctrl_q <= wr_ctrl ? REG_WDATA[5:0] : ctrl_q;
            rate_q <= wr_rate ? REG_WDATA : rate_q;
            minp_q <= wr_minp ? REG_WDATA : minp_q;
            shutter_q <= wr_shut ? REG_WDATA : shutter_q;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            eff_shutter_q <= `FSTC_RST_SHUT;
        end else if (accept && !fast_eff) begin
            eff_shutter_q <= shutter_q;
        end else if (frame_end && fast_eff) begin
            eff_shutter_q <= shutter_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port and outputs

    assign rdata_d = !REG_RD ? 32'h0 :
                     (REG_ADDR == `FSTC_OFF_CTRL) ? {26'h0, ctrl_q} :
                     (REG_ADDR == `FSTC_OFF_RATE) ? rate_q :
                     (REG_ADDR == `FSTC_OFF_MINP) ? minp_q :
                     (REG_ADDR == `FSTC_OFF_SHUT) ? shutter_q :
                     (REG_ADDR == `FSTC_OFF_STAT) ? {frame_cnt_q, 11'h0, level_active, armed_q, state_q} :
                     (REG_ADDR == `FSTC_OFF_APPL) ? eff_shutter_q : 32'h0;

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            REG_RDATA <= 32'h0;
            EXPOSURE_ACTIVE <= 1'b0;
            FRAME_START <= 1'b0;
            FRAME_BUSY <= 1'b0;
            ACQ_ARMED <= 1'b0;
        end else begin
            REG_RDATA <= rdata_d;
            EXPOSURE_ACTIVE <= (state_d == FSTC_ST_EXP);
            FRAME_START <= accept;
            FRAME_BUSY <= (state_d == FSTC_ST_DLY) || (state_d == FSTC_ST_EXP) || (state_d == FSTC_ST_RD);
            ACQ_ARMED <= armed_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    chk_start_from_wait: assert property (@(posedge CLK_SYS) disable iff (RST)
        FRAME_START |-> ($past(state_q) == FSTC_ST_WAIT && FRAME_BUSY))
        else $error("frame started outside waiting state");

    chk_busy_drops_trigger: assert property (@(posedge CLK_SYS) disable iff (RST)
        (state_q != FSTC_ST_WAIT && trig) |=> !FRAME_START)
        else $error("trigger accepted while busy");

    chk_no_self_trigger: assert property (@(posedge CLK_SYS) disable iff (RST)
        (external_trigger_enable && !ext_trig && !late_width) |-> !accept)
        else $error("self trigger with external triggering on");

    chk_oneshot_self_disarm: assert property (@(posedge CLK_SYS) disable iff (RST)
        (frame_end && one_shot && !arm_cmd) |=> (!armed_q ##1 state_q == FSTC_ST_IDLE))
        else $error("one-shot did not disarm after frame");

    chk_disarm_idle_stop: assert property (@(posedge CLK_SYS) disable iff (RST)
        (disarm_cmd && !arm_cmd && state_q == FSTC_ST_WAIT) |=> ##1 (state_q == FSTC_ST_IDLE && !ACQ_ARMED))
        else $error("disarm while waiting did not stop");

    chk_pace_reload: assert property (@(posedge CLK_SYS) disable iff (RST)
        (run_cont && pace_expired && !arm_cmd) |=> pace_count == fstc_m1($past(pace_period)))
        else $error("pacing period not the slower of the two");

    chk_fast_reset_off: assert property (@(posedge CLK_SYS)
        RST |=> !fast_exposure_start)
        else $error("fast start not off after reset");

    chk_delay_before_exp: assert property (@(posedge CLK_SYS) disable iff (RST)
        (accept && !fast_eff) |=> (state_q == FSTC_ST_DLY)[*5] ##1 (state_q == FSTC_ST_EXP))
        else $error("exposure delay length wrong");

    chk_fast_direct_exp: assert property (@(posedge CLK_SYS) disable iff (RST)
        (accept && fast_eff) |=> (EXPOSURE_ACTIVE && eff_shutter_q == $past(eff_shutter_q)))
        else $error("fast start did not expose at once");

    chk_width_ends_exp: assert property (@(posedge CLK_SYS) disable iff (RST)
        (state_q == FSTC_ST_EXP && width_mode && !level_active) |=> (state_q == FSTC_ST_RD && !EXPOSURE_ACTIVE))
        else $error("width exposure outlived the pulse");

    chk_oneshot_single: assert property (@(posedge CLK_SYS) disable iff (RST)
        (accept && one_shot && !external_trigger_enable) |=> !shot_pend_q)
        else $error("one-shot trigger not consumed");

    chk_fast_needs_ext: assert property (@(posedge CLK_SYS) disable iff (RST)
        (accept && !external_trigger_enable) |=> (state_q == FSTC_ST_DLY))
        else $error("fast start used without external triggering");

    chk_cont_first_trigger: assert property (@(posedge CLK_SYS) disable iff (RST)
        (arm_cmd && !external_trigger_enable && !one_shot && !armed_q && state_q == FSTC_ST_IDLE) |=> ##1 accept)
        else $error("free run did not start on arm");

    chk_disarm_ends_frame: assert property (@(posedge CLK_SYS) disable iff (RST)
        (frame_end && !armed_q && !arm_cmd) |=> (state_q == FSTC_ST_IDLE && !FRAME_BUSY))
        else $error("disarmed run did not stop after its frame");

endmodule : fstc_frame_trigger

`default_nettype wire

//--- verif/fstc_trig_source.sv
// Purpose: model of the outside party driving the hardware trigger line
// Assumes: polarity 0 rising, 1 falling
// Notes: line rests at the inactive level between pulses
`timescale 1ns/1ps
`default_nettype none

module fstc_trig_source (
    // clock
    input wire logic clk,
    // polarity and line
    input wire logic polarity,
    output logic line_out
);
    logic active_q = 1'b0;

    ////////////////////////////////////////
    // line level follows the pulse flag
    always @(posedge clk) begin
        line_out <= active_q ? ~polarity : polarity;
    end

    ////////////////////////////////////////
    // one pulse per wanted frame, then a rest
    task automatic pulse(input int width, input int gap);
        active_q <= 1'b1;
        repeat (width) @(posedge clk);
        active_q <= 1'b0;
        repeat (gap + 1) @(posedge clk);
    endtask : pulse
endmodule : fstc_trig_source
`default_nettype wire

//--- verif/tb_top.sv
// Purpose: self-checking bench of the frame start trigger control
// Assumes: offsets and counts of the shared defines
// Notes: random lengths from a fixed xorshift seed
`timescale 1ns/1ps
`default_nettype none
`include "fstc_defs.svh"

module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic pol = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic hw_line, exp_on, fr_start, fr_busy, armed, exp_prev;
    logic [31:0] reg_rdata, rd_q;
    logic [31:0] seed = 32'he23e;
    int n_errors = 0;
    int comparisons = 0;
    int n_starts = 0;
    int cyc = 0;
    int t_start = 0;
    int gap = 0;
    int dly = 0;
    int exp_run = 0;
    int exp_len = 0;
    int n_ends = 0;
    int n0, e0, sh, w, k;
    logic [7:0] ra [6] = '{`FSTC_OFF_CTRL, `FSTC_OFF_RATE, `FSTC_OFF_MINP, `FSTC_OFF_SHUT, `FSTC_OFF_CMD, 8'h40};
    logic [31:0] rv [6] = '{32'h0, `FSTC_RST_RATE, `FSTC_RST_MINP, `FSTC_RST_SHUT, 32'h0, 32'h0};

    fstc_frame_trigger uut (.CLK_SYS(clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .HW_TRIGGER_INPUT(hw_line),
        .EXPOSURE_ACTIVE(exp_on), .FRAME_START(fr_start), .FRAME_BUSY(fr_busy), .ACQ_ARMED(armed));
    fstc_trig_source src (.clk(clk), .polarity(pol), .line_out(hw_line));

    initial begin
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////
    // frame monitor
    always @(posedge clk) begin
        cyc++;
        if (fr_start === 1'b1) begin
            n_starts++;
            gap = cyc - t_start;
            t_start = cyc;
        end
        if (exp_on === 1'b1 && exp_prev !== 1'b1) begin
            dly = cyc - t_start;
            exp_run = 0;
        end
        if (exp_on === 1'b1) exp_run++;
        if (exp_on !== 1'b1 && exp_prev === 1'b1) begin
            exp_len = exp_run;
            n_ends++;
        end
        exp_prev = exp_on;
    end

    ////////////////////////////////////////
    // helpers
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : next_rand

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t %s: seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask : rd

    task automatic wait_starts(input int n);
        for (int i = 0; i < 400 && n_starts < n; i++) @(posedge clk);
    endtask : wait_starts

    task automatic summarize();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    ////////////////////////////////////////
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (k = 0; k < 6; k++) begin
            rd(ra[k], rd_q);
            chk(rd_q, rv[k], "reset value");
        end
        // free-run one-shot, fast bit without external triggering
        for (k = 0; k < 2; k++) begin
            seed = next_rand(seed);
            sh = 1 + seed[2:0];
            wr(`FSTC_OFF_SHUT, sh);
            wr(`FSTC_OFF_CTRL, k ? 32'h21 : 32'h01);
            n0 = n_starts;
            wr(`FSTC_OFF_CMD, 32'h1);
            idle(60);
            chk(n_starts - n0, 1, "one-shot count");
            chk(exp_len, sh, "shutter length");
            chk(dly, 5, "start delay");
            chk(armed, 0, "self disarm");
        end
        // continuous free-run pacing and disarm mid-frame
        for (k = 0; k < 2; k++) begin
            seed = next_rand(seed);
            w = 60 + seed[3:0];
            wr(`FSTC_OFF_RATE, k ? 40 : w);
            wr(`FSTC_OFF_MINP, k ? w : 40);
            wr(`FSTC_OFF_CTRL, 32'h0);
            n0 = n_starts;
            wr(`FSTC_OFF_CMD, 32'h1);
            wait_starts(n0 + 3);
            chk(gap, w, "free-run period");
            wr(`FSTC_OFF_CMD, 32'h2);
            n0 = n_starts;
            e0 = n_ends;
            idle(90);
            chk(n_starts - n0, 0, "no start after disarm");
            chk(n_ends - e0, 1, "running frame exposure completed");
            chk(exp_len, sh, "running frame finished");
            chk(armed, 0, "disarmed");
        end
        // soft fire, fast start off then on
        for (k = 0; k < 2; k++) begin
            wr(`FSTC_OFF_SHUT, sh + 1 - k);
            wr(`FSTC_OFF_CTRL, k ? 32'h22 : 32'h02);
            wr(`FSTC_OFF_CMD, 32'h1);
            n0 = n_starts;
            src.pulse(3, 40);
            chk(n_starts - n0, 0, "line ignored, no self trigger");
            wr(`FSTC_OFF_CMD, 32'h4);
            wr(`FSTC_OFF_CMD, 32'h4);
            chk(fr_busy, 1, "busy during frame");
            idle(60);
            chk(fr_busy, 0, "busy cleared after frame");
            chk(n_starts - n0, 1, "fire while busy dropped");
            chk(k ? (dly < 5) : (dly == 5), 1, "exposure start delay");
            chk(exp_len, sh + 1, "soft fire shutter");
            wr(`FSTC_OFF_CMD, 32'h2);
        end
        // mid-run reset clears the fast start setting
        rst <= 1'b1;
        idle(3);
        rst <= 1'b0;
        @(posedge clk);
        rd(`FSTC_OFF_CTRL, rd_q);
        chk(rd_q, 32'h0, "control after mid-run reset");
        wr(`FSTC_OFF_SHUT, sh);
        // hardware line, timed, both polarities
        for (k = 0; k < 2; k++) begin
            pol <= k[0];
            wr(`FSTC_OFF_CTRL, 32'h06 | (k << 3));
            wr(`FSTC_OFF_CMD, 32'h1);
            n0 = n_starts;
            wr(`FSTC_OFF_CMD, 32'h4);
            idle(30);
            chk(n_starts - n0, 0, "fire ignored with line origin");
            src.pulse(3, 8);
            src.pulse(3, 50);
            chk(n_starts - n0, 1, "edge while busy dropped");
            src.pulse(3, 50);
            chk(n_starts - n0, 2, "second edge taken");
            chk(exp_len, sh, "timed hardware shutter");
            chk(dly, `FSTC_START_DELAY_CYC, "timed hardware start delay");
            wr(`FSTC_OFF_CMD, 32'h2);
        end
        // trigger width exposure, then an early pulse
        pol <= 1'b0;
        wr(`FSTC_OFF_CTRL, 32'h16);
        wr(`FSTC_OFF_CMD, 32'h1);
        n0 = n_starts;
        seed = next_rand(seed);
        w = 20 + seed[3:0];
        src.pulse(w, 40);
        chk(exp_len <= w && exp_len + 8 >= w, 1, "width exposure");
        src.pulse(w, 5);
        src.pulse(60, 40);
        chk(n_starts - n0, 3, "early pulse still taken");
        chk(exp_len > 0 && exp_len < 50, 1, "early pulse shortened");
        wr(`FSTC_OFF_CMD, 32'h2);
        idle(5);
        summarize();
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        summarize();
    end
endmodule : tb_top
`default_nettype wire
